// ==== hw/slot_ctrl_pkg.sv ====
// Package with register map, field layout and reset values of the slot-control block
package slot_ctrl_pkg;

  localparam logic [7:0]  SLOT_CONTROL_OFS = 8'h58;
  localparam logic [7:0]  SLOT_CAPS_OFS    = 8'h54;
  localparam logic [7:0]  SLOT_STATUS_OFS  = 8'h5a;
  localparam logic [7:0]  IRQ_MASK_OFS     = 8'h60;

  // Control field positions
  localparam int BUTTON_BIT   = 0;
  localparam int FAULT_BIT    = 1;
  localparam int LATCH_BIT    = 2;
  localparam int PRESENCE_BIT = 3;
  localparam int COMPLETE_BIT = 4;
  localparam int MASTER_BIT   = 5;
  localparam int ATTN_LSB     = 6;
  localparam int PWRL_LSB     = 8;
  localparam int POWER_BIT    = 10;
  localparam int INTERLK_BIT  = 11;
  localparam int LINK_BIT     = 12;

  // Capability bit positions
  localparam int CAP_BUTTON   = 0;
  localparam int CAP_POWER    = 1;
  localparam int CAP_LATCH    = 2;
  localparam int CAP_ATTN     = 3;
  localparam int CAP_PWRL     = 4;
  localparam int CAP_HOTPLUG  = 6;
  localparam int CAP_INTERLK  = 17;

  // Status bit positions (sticky events)
  localparam int ST_BUTTON    = 0;
  localparam int ST_FAULT     = 1;
  localparam int ST_LATCH     = 2;
  localparam int ST_PRESENCE  = 3;
  localparam int ST_COMPLETE  = 4;
  localparam int ST_LINK      = 8;

  localparam logic [1:0]  ATTN_RESET   = 2'h3;
  localparam logic [1:0]  PWRL_RESET   = 2'h1;
  localparam logic [1:0]  LAMP_RSVD    = 2'h0;
  localparam logic [15:0] STATUS_MASK  = 16'h011f;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;

  typedef struct packed {
    logic       link_active_notify_enable;
    logic       slot_power_ctrl;
    logic [1:0] power_lamp_ctrl;
    logic [1:0] attention_lamp_ctrl;
    logic       hotplug_irq_master_enable;
    logic       completion_notify_enable;
    logic       presence_notify_enable;
    logic       latch_sensor_notify_enable;
    logic       fault_notify_enable;
    logic       button_press_notify_enable;
  } slot_ctl_t;

  typedef struct packed {
    logic [1:0] attention_lamp;
    logic [1:0] power_lamp;
    logic       slot_power_off;
    logic       interlock_pulse;
  } slot_action_t;

endpackage

// ==== hw/slot_hotplug_control.sv ====
// Slot-control register bank with hot-plug event tracking and notification
//
// Overview of operation
// - Button press raises interrupt or wake when enabled
// - Power fault raises interrupt or wake when enabled
// - Latch sensor change raises interrupt or wake when enabled
// - Presence change raises interrupt or wake when enabled
// - Command completion raises interrupt only, never wake
// - Interrupts need the master enable bit set
// - Fields without capability read zero, ignore writes
// - Attention lamp resets off, read/write state
// - Attention lamp reads zero without its capability
// - Power lamp resets on, read/write state
// - Power lamp reads zero without its capability
// - Upstream port ignores power lamp writes
// - Bit 10 sets power: zero on, one off
// - Interlock bit reads zero, one toggles
// - Link-active change raises interrupt or wake when enabled
// - Bits 15:13 reserved, read zero
// - One write is one command, completion last
`timescale 1ns/1ps

module slot_hotplug_control #(
  parameter int          ADDR_W      = 8,
  parameter logic        UPSTREAM    = 1'b0,
  parameter logic [31:0] SLOT_CAPS   = 32'h0002_005f
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [15:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [15:0]       rdata_o,
  input  wire logic              button_press_i,
  input  wire logic              power_fault_i,
  input  wire logic              latch_open_i,
  input  wire logic              card_present_i,
  input  wire logic              link_active_i,
  output logic                   action_valid_o,
  input  wire logic              action_done_i,
  output logic      [1:0]        attention_lamp_o,
  output logic      [1:0]        power_lamp_o,
  output logic                   slot_power_off_o,
  output logic                   interlock_pulse_o,
  output logic                   irq_o,
  output logic                   wake_o
);

  // Pin synchronisers
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] prev_ff;
  wire  [4:0] pins = {link_active_i, card_present_i, latch_open_i, power_fault_i,
                      button_press_i};

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      prev_ff  <= 5'h00;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  wire button_evt   = sync2_ff[0] & ~prev_ff[0];
  wire fault_evt    = sync2_ff[1] & ~prev_ff[1];
  wire latch_evt    = sync2_ff[2] ^ prev_ff[2];
  wire presence_evt = sync2_ff[3] ^ prev_ff[3];
  wire link_evt     = sync2_ff[4] ^ prev_ff[4];

  // Capability gating
  wire cap_hp      = SLOT_CAPS[slot_ctrl_pkg::CAP_HOTPLUG];
  wire cap_button  = SLOT_CAPS[slot_ctrl_pkg::CAP_BUTTON];
  wire cap_power   = SLOT_CAPS[slot_ctrl_pkg::CAP_POWER];
  wire cap_latch   = SLOT_CAPS[slot_ctrl_pkg::CAP_LATCH];
  wire cap_attn    = SLOT_CAPS[slot_ctrl_pkg::CAP_ATTN];
  wire cap_pwrl    = SLOT_CAPS[slot_ctrl_pkg::CAP_PWRL];
  wire cap_interlk = SLOT_CAPS[slot_ctrl_pkg::CAP_INTERLK];

  slot_ctrl_pkg::slot_ctl_t ctl_ff;
  slot_ctrl_pkg::slot_ctl_t nxt_ctl;
  logic [15:0]              status_ff;
  logic [15:0]              nxt_status;
  logic [15:0]              mask_ff;
  logic                     busy_ff;
  logic                     pulse_ff;
  logic                     wake_ff;

  wire sel_ctl  = addr_i == ADDR_W'(slot_ctrl_pkg::SLOT_CONTROL_OFS);
  wire sel_caps = addr_i == ADDR_W'(slot_ctrl_pkg::SLOT_CAPS_OFS);
  wire sel_sts  = addr_i == ADDR_W'(slot_ctrl_pkg::SLOT_STATUS_OFS);
  wire sel_mask = addr_i == ADDR_W'(slot_ctrl_pkg::IRQ_MASK_OFS);
  wire wr_ctl   = wr_i & sel_ctl;

  // Writable control fields, each gated by its capability
  always_comb begin
    nxt_ctl = ctl_ff;
    if (wr_ctl) begin
      if (cap_button)
        nxt_ctl.button_press_notify_enable = wdata_i[slot_ctrl_pkg::BUTTON_BIT];
      if (cap_power)
        nxt_ctl.fault_notify_enable = wdata_i[slot_ctrl_pkg::FAULT_BIT];
      if (cap_latch)
        nxt_ctl.latch_sensor_notify_enable = wdata_i[slot_ctrl_pkg::LATCH_BIT];
      if (cap_hp) begin
        nxt_ctl.presence_notify_enable = wdata_i[slot_ctrl_pkg::PRESENCE_BIT];
        nxt_ctl.completion_notify_enable = wdata_i[slot_ctrl_pkg::COMPLETE_BIT];
        nxt_ctl.hotplug_irq_master_enable = wdata_i[slot_ctrl_pkg::MASTER_BIT];
        nxt_ctl.link_active_notify_enable = wdata_i[slot_ctrl_pkg::LINK_BIT];
      end
      // Reserved lamp code is dropped so the lamp keeps a legal state
      if (cap_attn &&
          wdata_i[slot_ctrl_pkg::ATTN_LSB +: 2] != slot_ctrl_pkg::LAMP_RSVD)
        nxt_ctl.attention_lamp_ctrl = wdata_i[slot_ctrl_pkg::ATTN_LSB +: 2];
      if (cap_pwrl && !UPSTREAM &&
          wdata_i[slot_ctrl_pkg::PWRL_LSB +: 2] != slot_ctrl_pkg::LAMP_RSVD)
        nxt_ctl.power_lamp_ctrl = wdata_i[slot_ctrl_pkg::PWRL_LSB +: 2];
      if (cap_power)
        nxt_ctl.slot_power_ctrl = wdata_i[slot_ctrl_pkg::POWER_BIT];
    end
  end

  wire toggle_req = wr_ctl & cap_interlk & wdata_i[slot_ctrl_pkg::INTERLK_BIT];

  // A write is one command; completion waits for the outward action to finish
  wire cmd_done = busy_ff & action_done_i;

  // Sticky status: set wins over a write-one clear
  wire [15:0] events = {7'h00, link_evt, 3'h0, cmd_done, presence_evt, latch_evt,
                        fault_evt, button_evt};
  wire        wr_sts = wr_i & sel_sts;
  always_comb begin
    nxt_status = status_ff;
    if (wr_sts)
      nxt_status = status_ff & ~wdata_i;
    nxt_status = (nxt_status | events) & slot_ctrl_pkg::STATUS_MASK;
  end

  wire [15:0] enables = {7'h00, ctl_ff.link_active_notify_enable, 3'h0,
                         ctl_ff.completion_notify_enable, ctl_ff.presence_notify_enable,
                         ctl_ff.latch_sensor_notify_enable, ctl_ff.fault_notify_enable,
                         ctl_ff.button_press_notify_enable};
  wire [15:0] pending = status_ff & enables & ~mask_ff;
  // Wake ignores command completion
  wire [15:0] wake_src = enables & events & ~(16'h0001 << slot_ctrl_pkg::ST_COMPLETE);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctl_ff <= '{attention_lamp_ctrl: slot_ctrl_pkg::ATTN_RESET,
                  power_lamp_ctrl:     slot_ctrl_pkg::PWRL_RESET,
                  default:             '0};
      status_ff    <= 16'h0000;
      mask_ff      <= slot_ctrl_pkg::IRQ_MASK_RST;
      busy_ff      <= 1'b0;
      pulse_ff     <= 1'b0;
      wake_ff      <= 1'b0;
    end else begin
      ctl_ff    <= nxt_ctl;
      status_ff <= nxt_status;
      if (wr_i && sel_mask)
        mask_ff <= wdata_i & slot_ctrl_pkg::STATUS_MASK;
      // The pulse asks the slot side to flip the interlock once
      pulse_ff <= toggle_req;
      if (wr_ctl)
        busy_ff <= 1'b1;
      else if (action_done_i)
        busy_ff <= 1'b0;
      wake_ff <= |wake_src & ~ctl_ff.hotplug_irq_master_enable;
    end
  end

  // Interrupt while master enable and an enabled flag pending
  assign irq_o = ctl_ff.hotplug_irq_master_enable & (|pending);
  assign wake_o = wake_ff;

  assign attention_lamp_o  = ctl_ff.attention_lamp_ctrl;
  assign power_lamp_o      = ctl_ff.power_lamp_ctrl;
  assign slot_power_off_o  = ctl_ff.slot_power_ctrl;
  assign interlock_pulse_o = pulse_ff;
  assign action_valid_o    = busy_ff;

  // Read view with capability masking
  wire [15:0] ctl_view = {3'h0,
                          ctl_ff.link_active_notify_enable,
                          1'b0,
                          ctl_ff.slot_power_ctrl & cap_power,
                          ctl_ff.power_lamp_ctrl & {2{cap_pwrl}},
                          ctl_ff.attention_lamp_ctrl & {2{cap_attn}},
                          ctl_ff.hotplug_irq_master_enable,
                          ctl_ff.completion_notify_enable,
                          ctl_ff.presence_notify_enable,
                          ctl_ff.latch_sensor_notify_enable,
                          ctl_ff.fault_notify_enable,
                          ctl_ff.button_press_notify_enable};
  wire [15:0] rd_mux = sel_ctl  ? ctl_view :
                       sel_caps ? SLOT_CAPS[15:0] :
                       sel_sts  ? status_ff :
                       sel_mask ? mask_ff : 16'h0000;

  always_ff @(posedge mclk_i) begin
    if (rst_i)
      rdata_o <= 16'h0000;
    else
      rdata_o <= rd_i ? rd_mux : 16'h0000;
  end

endmodule

// ==== tb/slot_hotplug_control_asserts.sv ====
// Port-level checks of the slot-control block
`timescale 1ns/1ps
module slot_hotplug_control_asserts #(
  parameter int          ADDR_W    = 8,
  parameter logic        UPSTREAM  = 1'b0,
  parameter logic [31:0] SLOT_CAPS = 32'h0002_005f
) (
  input wire logic              mclk_i,
  input wire logic              rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0]       wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [15:0]       rdata_o,
  input wire logic              action_valid_o,
  input wire logic              action_done_i,
  input wire logic [1:0]        attention_lamp_o,
  input wire logic [1:0]        power_lamp_o,
  input wire logic              slot_power_off_o,
  input wire logic              interlock_pulse_o,
  input wire logic              irq_o,
  input wire logic              wake_o
);
  wire ctl_hit = addr_i == ADDR_W'(slot_ctrl_pkg::SLOT_CONTROL_OFS);
  wire ctl_wr  = wr_i && ctl_hit;
  logic master_ff, tog_ff, rd_ctl_ff;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      master_ff <= 1'b0;
      tog_ff    <= 1'b0;
      rd_ctl_ff <= 1'b0;
    end else begin
      master_ff <= ctl_wr ? wdata_i[5] & SLOT_CAPS[6] : master_ff;
      tog_ff    <= ctl_wr & wdata_i[11] & SLOT_CAPS[17];
      rd_ctl_ff <= rd_i && ctl_hit;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  irq_needs_master_a: assert property (irq_o |-> master_ff)
    else $error("irq without master enable");
  lamp_reset_a: assert property ($fell(rst_i) |->
    attention_lamp_o == 2'h3 && power_lamp_o == 2'h1) else $error("lamp reset state");
  attn_write_a: assert property (ctl_wr && wdata_i[7:6] != 2'h0 && SLOT_CAPS[3] |=>
    attention_lamp_o == $past(wdata_i[7:6])) else $error("attention lamp not set");
  pwr_write_a: assert property (ctl_wr && wdata_i[9:8] != 2'h0 && SLOT_CAPS[4] |=>
    power_lamp_o == (UPSTREAM ? $past(power_lamp_o) : $past(wdata_i[9:8])))
    else $error("power lamp wrong");
  power_ctl_a: assert property (ctl_wr && SLOT_CAPS[1] |=>
    slot_power_off_o == $past(wdata_i[10])) else $error("slot power wrong");
  toggle_pulse_a: assert property (interlock_pulse_o == tog_ff)
    else $error("interlock pulse wrong");
  rsvd_zero_a: assert property (rd_ctl_ff |->
    rdata_o[15:13] == 3'h0 && rdata_o[11] == 1'b0) else $error("reserved bits set");
  cmd_busy_a: assert property (ctl_wr |=> action_valid_o)
    else $error("command not busy");
  done_ends_a: assert property (action_valid_o && action_done_i && !ctl_wr |=>
    !action_valid_o) else $error("command not ended");
  cover property ($rose(irq_o));
  cover property (wake_o);
  cover property ($fell(action_valid_o));
endmodule

// ==== tb/slot_side_model.sv ====
// Slot-side model answering each control command after a set delay
`timescale 1ns/1ps
module slot_side_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       busy_i,
  input  wire logic [3:0] delay_i,
  output logic            done_o
);
  logic [3:0] cnt_ff;
  logic       sent_ff;
  always_ff @(posedge mclk_i) begin
    if (rst_i || !busy_i) begin
      cnt_ff  <= 4'h0;
      sent_ff <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      cnt_ff  <= cnt_ff + 4'h1;
      done_o  <= !sent_ff && cnt_ff == delay_i;
      sent_ff <= sent_ff || cnt_ff == delay_i;
    end
  end
endmodule

// ==== tb/slot_hotplug_control_bench.sv ====
// Self-checking bench for the slot-control register bank
`timescale 1ns/1ps
module slot_hotplug_control_bench;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, done;
  logic [7:0]  addr = 8'h0;
  logic [15:0] wdata = 16'h0, d, rdata;
  logic [4:0]  pins = 5'h0;
  logic [3:0]  dly = 4'h0;
  logic [1:0]  att, pwl;
  logic        busy, poff, tog, irq, wake;
  int          failures = 0, num_checks = 0, wakes = 0;
  always #10 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wakes++;
  slot_hotplug_control uut (.mclk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .button_press_i(pins[0]),
    .power_fault_i(pins[1]), .latch_open_i(pins[2]), .card_present_i(pins[3]),
    .link_active_i(pins[4]), .action_valid_o(busy), .action_done_i(done),
    .attention_lamp_o(att), .power_lamp_o(pwl), .slot_power_off_o(poff),
    .interlock_pulse_o(tog), .irq_o(irq), .wake_o(wake));
  slot_side_model partner (.mclk_i(clk), .rst_i(rst), .busy_i(busy), .delay_i(dly),
    .done_o(done));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrt(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle();
    #1;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk) #1;
    if (busy !== 1'b0) failures++;
  endtask
  task automatic press();
    @(posedge clk);
    pins[0] <= 1'b0;
    repeat (3) @(posedge clk);
    pins[0] <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdt(8'h58);
    chk(d, 16'h01c0);
    chk({att, pwl}, 16'hd);
    wrt(8'h58, 16'hffff);
    #1 chk(tog, 1'b1);
    chk(busy, 1'b1);
    rdt(8'h58);
    chk(d, 16'h17ff);
    chk({att, pwl, poff}, 16'h1f);
    settle();
    rdt(8'h5a);
    chk(d, 16'h0010);
    chk(irq, 1'b1);
    wrt(8'h5a, 16'hffff);
    #1 chk(irq, 1'b0);
    dly <= 4'h6;
    wrt(8'h58, 16'h1021);
    #1 chk(tog, 1'b0);
    rdt(8'h58);
    chk(d, 16'h13e1);
    settle();
    wrt(8'h5a, 16'hffff);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      pins[i] <= 1'b1;
      repeat (5) @(posedge clk);
      rdt(8'h5a);
      chk(d, (i == 4) ? 16'h0100 : 16'h0001 << i);
      chk(irq, i == 0 || i == 4);
      wrt(8'h5a, 16'hffff);
    end
    wrt(8'h60, 16'h0001);
    press();
    chk(irq, 1'b0);
    wrt(8'h60, 16'h0000);
    #1 chk(irq, 1'b1);
    wrt(8'h5a, 16'hffff);
    wrt(8'h58, 16'h0011);
    settle();
    chk(16'(wakes), 16'h0);
    wrt(8'h5a, 16'hffff);
    press();
    chk(16'(wakes), 16'h1);
    chk(irq, 1'b0);
    rdt(8'h70);
    chk(d, 16'h0);
    report_and_stop();
  end
endmodule
bind slot_hotplug_control slot_hotplug_control_asserts #(.ADDR_W(ADDR_W),
  .UPSTREAM(UPSTREAM), .SLOT_CAPS(SLOT_CAPS)) chk_i (.*);
